// File: pkg/rfc_pkg.sv
// Shared constants, register map and types of the redundancy failover controller
package rfc_pkg;
    localparam int NUM_ALARMS = 19;
    localparam int CLK_HZ = 20_000_000;
    localparam int GUARD_S = 20;
    localparam int GUARD_CYCLES = GUARD_S * CLK_HZ;
    localparam int SWITCH_MS = 500;
    localparam int SWITCH_CYCLES = (SWITCH_MS * (CLK_HZ / 1000));
    localparam int KEEPALIVE_CYCLES = 20_000_000;
    localparam int CNT_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIG_EN = 8'h04;
    localparam logic [7:0] ADDR_BLOCK_EN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_ID = 8'h10;
    localparam logic [31:0] ID_VALUE = 32'h0000_5A5A;
    localparam int CTRL_LOCK_LSB = 0;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_GUARD_BIT = 1;
    localparam int ST_PENDING_BIT = 2;
    localparam int ST_KA_LOST_BIT = 3;
    localparam int ST_LED_LSB = 4;
    localparam int ST_SWCNT_LSB = 8;
    localparam logic [18:0] TRIG_EN_RST = 19'h7_FFFF;
    localparam logic [18:0] BLOCK_EN_RST = 19'h0_0000;
    typedef enum logic [1:0] {
        RFC_SW_AUTO = 2'h0,
        RFC_SW_PRIMARY = 2'h1,
        RFC_SW_SECONDARY = 2'h2
    } rfc_sw_lock_t;
    typedef enum logic [1:0] {
        RFC_HW_AUTO = 2'h0,
        RFC_HW_A = 2'h1,
        RFC_HW_B = 2'h2
    } rfc_hw_lock_t;
    typedef struct packed {
        logic [NUM_ALARMS-1:0] alarm;
        logic power_fail;
        logic powered;
        logic keepalive;
    } rfc_unit_t;
    typedef struct packed {
        logic led_a_orange;
        logic led_b_orange;
        logic led_auto_green;
    } rfc_leds_t;
endpackage : rfc_pkg

// File: design/rfc_sync.sv
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module rfc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    pclk,
    presetn,
    d,
    q
);
    input wire logic pclk;
    input wire logic presetn;
    input wire logic [W-1:0] d;
    output logic [W-1:0] q;
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Value moves only when stages two and three agree
            assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q <= RST;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= q_nxt;
        end
    end
endmodule : rfc_sync

// File: design/rfc_top.sv
// Redundancy failover controller: active unit selection, locks, LEDs and APB registers
//
// Overview of operation
// RULE_01 - Switch on enabled alarm or keep-alive loss
// RULE_02 - Per-alarm trigger and blocking enables
// RULE_03 - Standby power fail or blocking alarm suppresses
// RULE_04 - Suppressed switch happens when inhibit clears
// RULE_05 - Hardware lock A/B forces that unit
// RULE_06 - Hardware auto follows normal evaluation only
// RULE_07 - LEDs show A, B or auto lock
// RULE_08 - Exactly one LED lit
// RULE_09 - Hardware lock beats software lock
// RULE_10 - Hardware auto re-applies software lock
// RULE_11 - Remote input only in hardware auto
// RULE_12 - Remote input active low, idle high
// RULE_13 - Software lock primary, secondary, automatic
// RULE_14 - Releasing lock causes no revert
// RULE_15 - Twenty second guard after switch-over
// RULE_16 - Primary active at power-up, else powered
// RULE_17 - Switch completes within half second
// RULE_18 - Keep-alive timeout in clock ticks
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module rfc_top
    import rfc_pkg::*;
#(
    parameter int GUARD_TICKS = rfc_pkg::GUARD_CYCLES,
    parameter int KA_TICKS = rfc_pkg::KEEPALIVE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rfc_pkg::rfc_unit_t unit_a,
    input wire rfc_pkg::rfc_unit_t unit_b,
    input wire logic [1:0] hw_lock,
    input wire logic remote_switch_n,
    output logic active_b,
    output rfc_pkg::rfc_leds_t leds
);
    import rfc_pkg::*;

    localparam int UW = $bits(rfc_unit_t);

    // Synchronised pin inputs
    rfc_unit_t ua_s;
    rfc_unit_t ub_s;
    logic [1:0] hw_s;
    logic remote_n_s;

    rfc_sync #(.W(UW)) u_sync_a (.pclk(pclk), .presetn(presetn), .d(unit_a), .q(ua_s));
    rfc_sync #(.W(UW)) u_sync_b (.pclk(pclk), .presetn(presetn), .d(unit_b), .q(ub_s));
    rfc_sync #(.W(2)) u_sync_hw (.pclk(pclk), .presetn(presetn), .d(hw_lock), .q(hw_s));
    rfc_sync #(.W(1), .RST(1'b1)) u_sync_rm (.pclk(pclk), .presetn(presetn), .d(remote_switch_n), .q(remote_n_s));

    // Registers
    logic [1:0] sw_lock_r;
    logic [NUM_ALARMS-1:0] trig_en_r;
    logic [NUM_ALARMS-1:0] block_en_r;
    logic active_b_r;
    logic active_b_nxt;
    logic started_r;
    // Start-up waits until the pin synchronisers hold real values;
    // otherwise a unit still seen as unpowered would pend a phantom switch
    logic [3:0] settle_r;
    logic pending_r;
    logic pending_nxt;
    logic [CNT_W-1:0] guard_cnt_r;
    logic [CNT_W-1:0] ka_cnt_r;
    logic ka_prev_r;
    logic remote_prev_r;
    logic [1:0] hw_prev_r;
    logic [15:0] sw_count_r;
    logic [31:0] prdata_r;

    // Active and standby views
    rfc_unit_t act_u;
    rfc_unit_t stb_u;
    assign act_u = active_b_r ? ub_s : ua_s;
    assign stb_u = active_b_r ? ua_s : ub_s;

    // Keep-alive watchdog on rising edges of the active unit's indication
    wire ka_edge = act_u.keepalive & ~ka_prev_r;
    wire ka_lost = (ka_cnt_r >= CNT_W'(KA_TICKS)); // RULE_18

    // Trigger and blocking evaluation
    wire [NUM_ALARMS-1:0] act_trig = act_u.alarm & trig_en_r; // RULE_02
    wire [NUM_ALARMS-1:0] stb_block = stb_u.alarm & block_en_r; // RULE_02
    wire trigger = (|act_trig) | ka_lost | ~act_u.powered; // RULE_01
    wire inhibit = stb_u.power_fail | ~stb_u.powered | (|stb_block); // RULE_03
    wire guard_busy = (guard_cnt_r != '0); // RULE_15

    // Remote control: falling edge of the low-active input is a request
    wire remote_req = remote_prev_r & ~remote_n_s; // RULE_12

    wire hw_auto = (hw_s == RFC_HW_AUTO); // RULE_06
    wire hw_forced = (hw_s == RFC_HW_A) | (hw_s == RFC_HW_B);
    wire hw_target_b = (hw_s == RFC_HW_B);
    wire sw_forced = (sw_lock_r == RFC_SW_PRIMARY) | (sw_lock_r == RFC_SW_SECONDARY);
    wire sw_target_b = (sw_lock_r == RFC_SW_SECONDARY);
    // Leaving a hardware lock re-applies the software lock, but an auto setting keeps the current unit
    wire hw_released = (hw_prev_r != RFC_HW_AUTO) & hw_auto; // RULE_10

    // Want to move away from the current active unit
    wire auto_want = (trigger | pending_r | (remote_req & hw_auto)); // RULE_11

    always_comb begin
        active_b_nxt = active_b_r;
        pending_nxt = pending_r;
        if (!started_r) begin
            // Primary unless only the secondary is powered
            active_b_nxt = ~ua_s.powered & ub_s.powered; // RULE_16
            pending_nxt = 1'b0;
        end else if (hw_forced) begin
            active_b_nxt = hw_target_b; // RULE_05 RULE_09
            pending_nxt = 1'b0;
        end else if (sw_forced) begin
            active_b_nxt = sw_target_b; // RULE_13 RULE_10
            pending_nxt = 1'b0;
        end else if (auto_want) begin
            // Hold the request while inhibited or guarded so it fires on clearing
            if (inhibit || guard_busy) begin
                pending_nxt = trigger | pending_r | (remote_req & hw_auto); // RULE_04 RULE_15
            end else begin
                active_b_nxt = ~active_b_r; // RULE_01 RULE_17
                pending_nxt = 1'b0;
            end
        end
        // No revert on release: without a software lock, only a trigger, pending or remote request moves the unit
        if (hw_released && !sw_forced && !auto_want) begin
            active_b_nxt = active_b_r; // RULE_14
        end
    end

    wire switched = started_r & (active_b_nxt != active_b_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_b_r <= 1'b0;
            pending_r <= 1'b0;
            started_r <= 1'b0;
            settle_r <= 4'h0;
        end else begin
            active_b_r <= active_b_nxt;
            pending_r <= pending_nxt;
            settle_r <= {settle_r[2:0], 1'b1};
            started_r <= settle_r[3]; // RULE_16
        end
    end

    // Guard timer and keep-alive watchdog; a switch restarts both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_cnt_r <= '0;
        end else if (switched) begin
            guard_cnt_r <= CNT_W'(GUARD_TICKS); // RULE_15
        end else if (guard_busy) begin
            guard_cnt_r <= guard_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ka_cnt_r <= '0;
        end else if (switched || ka_edge || !started_r) begin
            ka_cnt_r <= '0; // RULE_18
        end else if (!ka_lost) begin
            ka_cnt_r <= ka_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ka_prev_r <= 1'b0;
            remote_prev_r <= 1'b1;
            hw_prev_r <= 2'h0;
            sw_count_r <= 16'h0000;
        end else begin
            ka_prev_r <= switched ? 1'b0 : act_u.keepalive;
            remote_prev_r <= remote_n_s;
            hw_prev_r <= hw_s;
            if (switched) begin
                sw_count_r <= sw_count_r + 16'h0001;
            end
        end
    end

    // LEDs: one-hot from the lock position and active unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds <= '{led_a_orange: 1'b0, led_b_orange: 1'b0, led_auto_green: 1'b1};
        end else begin
            leds.led_a_orange <= hw_forced & ~active_b_nxt; // RULE_07 RULE_08
            leds.led_b_orange <= hw_forced & active_b_nxt; // RULE_07 RULE_08
            leds.led_auto_green <= ~hw_forced; // RULE_07 RULE_08
        end
    end

    assign active_b = active_b_r;

    // APB slave: zero wait states, unmapped addresses raise pslverr
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire sel_ctrl = (paddr == ADDR_CTRL);
    wire sel_trig = (paddr == ADDR_TRIG_EN);
    wire sel_blk = (paddr == ADDR_BLOCK_EN);
    wire sel_st = (paddr == ADDR_STATUS);
    wire sel_id = (paddr == ADDR_ID);
    wire mapped = sel_ctrl | sel_trig | sel_blk | sel_st | sel_id;
    // The unused fourth lock code is refused so software cannot park in an undefined mode
    wire lock_ok = (pwdata[CTRL_LOCK_LSB +: 2] != 2'h3);

    wire [31:0] status_word = {8'h00, sw_count_r, 1'b0, leds, ka_lost, pending_r, guard_busy, active_b_r};
    wire [31:0] rd_mux = sel_ctrl ? {30'h0000_0000, sw_lock_r} :
                         sel_trig ? {13'h0000, trig_en_r} :
                         sel_blk ? {13'h0000, block_en_r} :
                         sel_st ? status_word :
                         sel_id ? ID_VALUE : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_lock_r <= 2'h0;
            trig_en_r <= TRIG_EN_RST;
            block_en_r <= BLOCK_EN_RST;
        end else if (apb_wr) begin
            if (sel_ctrl && lock_ok) begin
                sw_lock_r <= pwdata[CTRL_LOCK_LSB +: 2]; // RULE_13
            end
            if (sel_trig) begin
                trig_en_r <= pwdata[NUM_ALARMS-1:0]; // RULE_02
            end
            if (sel_blk) begin
                block_en_r <= pwdata[NUM_ALARMS-1:0]; // RULE_02
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = apb_acc & (~mapped | (pwrite & (sel_st | sel_id)) | (pwrite & sel_ctrl & ~lock_ok));

endmodule : rfc_top

// File: sim/rfc_props.sv
// Port checker for the redundancy failover controller
`timescale 1ns/1ps
module rfc_props
    import rfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] hw_lock,
    input wire logic active_b,
    input wire rfc_pkg::rfc_leds_t leds
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Eight samples leave room for the input synchroniser
    a_led_onehot: assert property ($onehot(leds))
        else $error("leds not one-hot");
    a_led_auto: assert property ((hw_lock == 2'h0) [*8] |-> leds.led_auto_green)
        else $error("auto led off");
    a_force_a: assert property ((hw_lock == 2'h1) [*8] |-> !active_b && leds.led_a_orange)
        else $error("lock A not applied");
    a_force_b: assert property ((hw_lock == 2'h2) [*8] |-> active_b && leds.led_b_orange)
        else $error("lock B not applied");
    a_lock_hold: assert property ((hw_lock == 2'h2) [*8] ##1 (hw_lock == 2'h2) |-> $stable(active_b))
        else $error("active unit moved under lock");
    a_reset_primary: assert property ($rose(presetn) |-> !active_b && leds.led_auto_green)
        else $error("reset state wrong");
    a_led_a_unit: assert property (leds.led_a_orange [*2] |-> !active_b)
        else $error("A led with B active");
    a_led_b_unit: assert property (leds.led_b_orange [*2] |-> active_b)
        else $error("B led with A active");
    c_switch: cover property (hw_lock == 2'h0 && $changed(active_b));
    c_lock_a: cover property (leds.led_a_orange);
    c_lock_b: cover property (leds.led_b_orange);
endmodule : rfc_props

// File: sim/rfc_units.sv
// Behavioural model of the two redundant radio units
`timescale 1ns/1ps
module rfc_units
    import rfc_pkg::*;
#(
    parameter int KA_PER = 8
) (
    input wire logic pclk,
    input wire logic [18:0] al_a,
    input wire logic [18:0] al_b,
    input wire logic [1:0] pf,
    input wire logic [1:0] ka_on,
    output rfc_pkg::rfc_unit_t unit_a,
    output rfc_pkg::rfc_unit_t unit_b
);
    int cnt = 0;
    logic ka = 1'b0;
    // A silent unit holds its line low, so no edge reaches the switch
    always @(posedge pclk) begin
        cnt <= (cnt + 1) % (KA_PER / 2);
        if (cnt == 0) ka <= !ka;
    end
    assign unit_a = {al_a, pf[0], 1'b1, ka & ka_on[0]};
    assign unit_b = {al_b, pf[1], 1'b1, ka & ka_on[1]};
endmodule : rfc_units

// File: sim/tb_rfc_top.sv
// Self-checking bench of the redundancy failover controller
`timescale 1ns/1ps
module tb_rfc_top;
    import rfc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rsw_n = 1'b1;
    logic pready, pslverr, active_b, er;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, rs = 32'h0000_7ed6;
    logic [18:0] al_a = '0, al_b = '0;
    logic [1:0] hw_lock = '0, pf = '0, ka_on = 2'h3;
    rfc_unit_t unit_a, unit_b;
    rfc_leds_t leds;
    int mismatches = 0, checked = 0, exp_b = 0, k;
    rfc_top #(.GUARD_TICKS(50), .KA_TICKS(40)) i_rfc_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .unit_a, .unit_b, .hw_lock,
        .remote_switch_n(rsw_n), .active_b, .leds);
    rfc_units i_rfc_units (.pclk, .al_a, .al_b, .pf, .ka_on, .unit_a, .unit_b);
    always #25 pclk = !pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wt(input int n);
        for (int i = 0; i < n && active_b !== exp_b[0]; i++) @(posedge pclk);
        chk("active_b", active_b, exp_b);
    endtask : wt
    task automatic stay(input int n);
        repeat (n) @(posedge pclk);
        chk("active_b", active_b, exp_b);
    endtask : stay
    task automatic alarm(input int u, input int b, input logic v);
        if (u != 0) al_b[b] <= v;
        else al_a[b] <= v;
    endtask : alarm
    task automatic clr(input int n);
        al_a <= '0;
        al_b <= '0;
        pf <= '0;
        ka_on <= 2'h3;
        repeat (n) @(posedge pclk);
    endtask : clr
    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("active_b", active_b, exp_b);
        chk("leds", leds, 3'h1);
        apb(1'b0, ADDR_TRIG_EN, '0);
        chk("trig_en", rd, 32'h0007_FFFF);
        apb(1'b0, 8'h40, '0);
        chk("unmapped", er, 1);
        for (int n = 0; n < 3; n++) begin
            rs = lfsr(rs);
            k = rs % 19;
            alarm(exp_b, k, 1'b1);
            exp_b ^= 1;
            wt(20);
            clr(60);
        end
        alarm(exp_b, 3, 1'b1);
        exp_b ^= 1;
        wt(20);
        clr(1);
        alarm(exp_b, 5, 1'b1);
        stay(30);
        exp_b ^= 1;
        wt(40);
        clr(60);
        apb(1'b1, ADDR_BLOCK_EN, 32'h0000_0004);
        chk("wr_err", er, 0);
        apb(1'b0, ADDR_BLOCK_EN, '0);
        chk("block_en", rd, 32'h0000_0004);
        for (int i = 0; i < 2; i++) begin
            if (i != 0) pf[!exp_b] <= 1'b1;
            else alarm(!exp_b, 2, 1'b1);
            alarm(exp_b, 7, 1'b1);
            stay(30);
            pf <= '0;
            alarm(!exp_b, 2, 1'b0);
            exp_b ^= 1;
            wt(20);
            clr(60);
        end
        apb(1'b1, ADDR_TRIG_EN, 32'h0007_FDFF);
        alarm(exp_b, 9, 1'b1);
        stay(30);
        alarm(exp_b, 10, 1'b1);
        exp_b ^= 1;
        wt(20);
        clr(60);
        ka_on[exp_b] <= 1'b0;
        stay(25);
        exp_b ^= 1;
        wt(40);
        clr(60);
        hw_lock <= (exp_b != 0) ? 2'h1 : 2'h2;
        exp_b ^= 1;
        wt(20);
        chk("leds", leds, (exp_b != 0) ? 3'h2 : 3'h4);
        apb(1'b1, ADDR_CTRL, (exp_b != 0) ? 32'h0000_0001 : 32'h0000_0002);
        stay(10);
        rsw_n <= 1'b0;
        stay(10);
        rsw_n <= 1'b1;
        stay(10);
        hw_lock <= 2'h0;
        exp_b ^= 1;
        wt(20);
        apb(1'b1, ADDR_CTRL, '0);
        stay(60);
        chk("leds", leds, 3'h1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        chk("lock_err", er, 1);
        rsw_n <= 1'b0;
        exp_b ^= 1;
        wt(20);
        end_of_test();
    end
endmodule : tb_rfc_top
bind rfc_top rfc_props i_rfc_props (.pclk, .presetn, .hw_lock, .active_b, .leds);
